//--- hw/sector_prot_pkg.sv
package sector_prot_pkg;
    localparam int          NUM_UNITS     = 542;
    localparam int          BLOCK_UNITS   = 510;
    localparam int          ADDR_W        = 25;
    localparam int          IDX_W         = 10;
    localparam int          BLOCK_LSB     = 16;
    localparam int          SECTOR_LSB    = 12;
    localparam int          CNT_W         = 24;
    localparam int          CLK_MHZ       = 20;
    localparam int          T_UNLOCK_US   = 100;
    localparam int          UNLOCK_CYCLES = T_UNLOCK_US * CLK_MHZ;
    localparam int          T_PROG_US     = 200;
    localparam int          T_ERASE_US    = 45000;
    localparam logic [8:0]  TOP_BLOCK     = 9'h1FE;

    typedef enum logic [3:0] {
        CMD_PPB_PROG   = 4'h1,
        CMD_PPB_ERASE  = 4'h2,
        CMD_PPB_READ   = 4'h3,
        CMD_DYB_WRITE  = 4'h4,
        CMD_DYB_READ   = 4'h5,
        CMD_LOCK_CLEAR = 4'h6,
        CMD_UNLOCK     = 4'h7,
        CMD_ARRAY_WR   = 4'h8,
        CMD_ARRAY_RD   = 4'h9
    } cmd_e;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_PROG   = 4'b0010,
        ST_ERASE  = 4'b0100,
        ST_UNLOCK = 4'b1000
    } state_e;
endpackage

//--- hw/prot_store_if.sv
`timescale 1ns/100ps
`default_nettype none
interface prot_store_if;
    import sector_prot_pkg::*;
    logic [IDX_W-1:0] idx;
    logic             ppb_prog;
    logic             ppb_erase_all;
    logic             dyb_we;
    logic             dyb_val;
    logic             dyb_reset_all;
    logic             ppb_bit;
    logic             dyb_bit;
    modport ctrl  (output idx, ppb_prog, ppb_erase_all, dyb_we, dyb_val, dyb_reset_all,
                   input ppb_bit, dyb_bit);
    modport store (input idx, ppb_prog, ppb_erase_all, dyb_we, dyb_val, dyb_reset_all,
                   output ppb_bit, dyb_bit);
endinterface
`default_nettype wire

//--- hw/prot_bit_store.sv
`timescale 1ns/100ps
`default_nettype none
module prot_bit_store (
    input  wire logic   clk_sys_in,
    prot_store_if.store io
);
    import sector_prot_pkg::*;

    // Persistent bits carry no reset: they model non-volatile cells, which leave the factory erased.
    logic [NUM_UNITS-1:0] ppb_q = '1;
    logic [NUM_UNITS-1:0] dyb_q;

    always_ff @(posedge clk_sys_in) begin
        if (io.ppb_prog) begin
            ppb_q[io.idx] <= 1'b0;
        end else if (io.ppb_erase_all) begin
            ppb_q <= '1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_UNITS; i++) begin : g_dyb
            always_ff @(posedge clk_sys_in) begin
                if (io.dyb_reset_all) begin
                    dyb_q[i] <= 1'b1;
                end else if (io.dyb_we && io.idx == IDX_W'(i)) begin
                    dyb_q[i] <= io.dyb_val;
                end
            end
        end
    endgenerate

    assign io.ppb_bit = ppb_q[io.idx];
    assign io.dyb_bit = dyb_q[io.idx];
endmodule
`default_nettype wire

//--- hw/sector_prot_bits.sv
`timescale 1ns/100ps
`default_nettype none
module sector_prot_bits #(
    parameter int PROG_CYCLES  = sector_prot_pkg::T_PROG_US * sector_prot_pkg::CLK_MHZ,
    parameter int ERASE_CYCLES = sector_prot_pkg::T_ERASE_US * sector_prot_pkg::CLK_MHZ
) (
    // Clock and resets.
    input  wire logic                           clk_sys_in,
    input  wire logic                           srst_in,
    input  wire logic                           soft_reset_in,
    // Static configuration.
    input  wire logic                           password_mode_in,
    // Command port.
    input  wire logic                           cmd_valid_in,
    input  wire sector_prot_pkg::cmd_e          cmd_op_in,
    input  wire logic [sector_prot_pkg::ADDR_W-1:0] cmd_addr_in,
    input  wire logic                           cmd_dyb_val_in,
    input  wire logic                           password_match_in,
    input  wire logic                           err_clear_in,
    // Status and answers.
    output logic                                write_in_progress_out,
    output logic                                lock_bit_out,
    output logic                                protection_error_flag_out,
    output logic                                program_error_out,
    output logic                                array_write_grant_out,
    output logic                                array_read_grant_out,
    output logic                                array_read_refused_out,
    output logic                                bit_read_valid_out,
    output logic                                bit_read_data_out
);
    import sector_prot_pkg::*;

    if (PROG_CYCLES < 1 || ERASE_CYCLES < 1 ||
        PROG_CYCLES >= 2**CNT_W || ERASE_CYCLES >= 2**CNT_W) begin : g_bad_cycles
        $error("Cycle counts out of range for the counter.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    prot_store_if io ();

    prot_bit_store u_store (
        .clk_sys_in (clk_sys_in),
        .io         (io.store)
    );

    state_e           state_q;
    state_e           state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             lock_q;
    logic             prot_err_q;
    logic             prog_err_q;
    logic             wip_q;
    logic             wr_grant_q;
    logic             rd_grant_q;
    logic             rd_refused_q;
    logic             bit_valid_q;
    logic             bit_data_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Unit decode: the two top blocks split into their 4K sectors.
    wire logic [8:0]        blk_num   = cmd_addr_in[ADDR_W-1:BLOCK_LSB];
    wire logic              top_area  = blk_num >= TOP_BLOCK;
    wire logic [4:0]        sect_num  = cmd_addr_in[BLOCK_LSB:SECTOR_LSB];
    wire logic [IDX_W-1:0]  unit_idx  = top_area ? IDX_W'(BLOCK_UNITS) + IDX_W'(sect_num)
                                                 : IDX_W'(blk_num);
    wire logic              unit_open = io.ppb_bit & io.dyb_bit;
    wire logic              idle      = state_q == ST_IDLE;
    wire logic              cmd_go    = cmd_valid_in & idle & ~soft_reset_in;
    wire logic              is_prog   = cmd_go & (cmd_op_in == CMD_PPB_PROG);
    wire logic              is_erase  = cmd_go & (cmd_op_in == CMD_PPB_ERASE);
    wire logic              is_unlock = cmd_go & (cmd_op_in == CMD_UNLOCK) & password_mode_in;
    wire logic              pw_miss   = is_unlock & ~password_match_in;
    wire logic              ppb_deny  = (is_prog | is_erase) & ~lock_q;
    wire logic              arr_wr    = cmd_go & (cmd_op_in == CMD_ARRAY_WR);
    wire logic              arr_deny  = arr_wr & ~unit_open;
    wire logic              rd_req    = cmd_valid_in & (cmd_op_in == CMD_ARRAY_RD);
    wire logic              bit_rd    = cmd_go & (cmd_op_in == CMD_PPB_READ || cmd_op_in == CMD_DYB_READ);
    wire logic              cnt_done  = cnt_q == '0;

    assign io.idx           = unit_idx;
    // Program and erase commit at the end of the interval, so the busy window is honest.
    assign io.ppb_prog      = (state_q == ST_PROG) & cnt_done;
    assign io.ppb_erase_all = (state_q == ST_ERASE) & cnt_done;
    assign io.dyb_we        = cmd_go & (cmd_op_in == CMD_DYB_WRITE);
    assign io.dyb_val       = cmd_dyb_val_in;
    assign io.dyb_reset_all = srst_in | soft_reset_in;

    ////////////////////////////////////////////////////////////////////////////////
    // The program index is not latched; it follows the address the host holds, so the host keeps it steady.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
        unique case (state_q)
            ST_IDLE: begin
                if (is_prog && lock_q) begin
                    state_d = ST_PROG;
                    cnt_d   = CNT_W'(PROG_CYCLES - 1);
                end else if (is_erase && lock_q) begin
                    state_d = ST_ERASE;
                    cnt_d   = CNT_W'(ERASE_CYCLES - 1);
                end else if (pw_miss) begin
                    state_d = ST_UNLOCK;
                    cnt_d   = CNT_W'(UNLOCK_CYCLES - 1);
                end
            end
            ST_PROG, ST_ERASE, ST_UNLOCK: begin
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end
            end
            // A corrupted state code falls back to idle rather than hanging busy.
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset here stands for power-up and hardware reset; software reset never reaches the lock.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            lock_q <= ~password_mode_in;
        end else if (cmd_go && cmd_op_in == CMD_LOCK_CLEAR) begin
            lock_q <= 1'b0;
        end else if (is_unlock && password_match_in) begin
            lock_q <= 1'b1;
        end
    end

    // A new error wins over a clear in the same cycle.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            prot_err_q <= 1'b0;
            prog_err_q <= 1'b0;
        end else if (ppb_deny || arr_deny || pw_miss) begin
            prot_err_q <= 1'b1;
            prog_err_q <= 1'b1;
        end else if (err_clear_in) begin
            prot_err_q <= 1'b0;
            prog_err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            wip_q        <= 1'b0;
            wr_grant_q   <= 1'b0;
            rd_grant_q   <= 1'b0;
            rd_refused_q <= 1'b0;
            bit_valid_q  <= 1'b0;
            bit_data_q   <= 1'b0;
        end else begin
            wip_q        <= state_d != ST_IDLE;
            wr_grant_q   <= arr_wr & unit_open;
            rd_grant_q   <= rd_req & idle & ~soft_reset_in;
            rd_refused_q <= rd_req & (state_q == ST_PROG);
            bit_valid_q  <= bit_rd;
            bit_data_q   <= (cmd_op_in == CMD_PPB_READ) ? io.ppb_bit : io.dyb_bit;
        end
    end

    assign write_in_progress_out     = wip_q;
    assign lock_bit_out              = lock_q;
    assign protection_error_flag_out = prot_err_q;
    assign program_error_out         = prog_err_q;
    assign array_write_grant_out     = wr_grant_q;
    assign array_read_grant_out      = rd_grant_q;
    assign array_read_refused_out    = rd_refused_q;
    assign bit_read_valid_out        = bit_valid_q;
    assign bit_read_data_out         = bit_data_q;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    property p_lock_reset;
        $fell(srst_in) |-> lock_q == ~password_mode_in;
    endproperty
    a_lock_reset: assert property (p_lock_reset) else $error("Lock wrong after reset.");

    property p_ppb_locked;
        ppb_deny |=> prot_err_q && state_q == ST_IDLE && !wip_q;
    endproperty
    a_ppb_locked: assert property (p_ppb_locked) else $error("Locked persistent change ran.");

    property p_unlock_wait;
        pw_miss |=> (state_q == ST_UNLOCK && cnt_q == CNT_W'(UNLOCK_CYCLES - 1)) ##0 wip_q [*3];
    endproperty
    a_unlock_wait: assert property (p_unlock_wait) else $error("Unlock delay not started.");

    property p_pw_miss;
        pw_miss |=> prot_err_q && prog_err_q && !lock_q;
    endproperty
    a_pw_miss: assert property (p_pw_miss) else $error("Mismatch handling wrong.");

    property p_lock_clear;
        cmd_go && cmd_op_in == CMD_LOCK_CLEAR |=> !lock_q ##1 !lock_q || $past(is_unlock);
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("Lock clear failed.");

    property p_soft_keeps_lock;
        soft_reset_in |=> $stable(lock_q) && io.dyb_bit;
    endproperty
    a_soft_keeps_lock: assert property (p_soft_keeps_lock) else $error("Soft reset misbehaved.");

    property p_grant_open;
        array_write_grant_out |-> $past(unit_open) && $past(arr_wr);
    endproperty
    a_grant_open: assert property (p_grant_open) else $error("Write granted to protected unit.");

    property p_read_refused;
        rd_req && state_q == ST_PROG |=> array_read_refused_out && !array_read_grant_out;
    endproperty
    a_read_refused: assert property (p_read_refused) else $error("Read allowed during program.");

    property p_lock_rise;
        $rose(lock_q) |-> $past(is_unlock) && $past(password_match_in);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("Lock raised by software.");

    c_erase_done:  cover property (state_q == ST_ERASE && cnt_done);
    c_unlock_ok:   cover property (is_unlock && password_match_in);
    c_write_grant: cover property (array_write_grant_out);
    c_read_refuse: cover property (array_read_refused_out);
endmodule
`default_nettype wire

//--- verif/prot_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module prot_host_model (
    // Clock.
    input  wire logic                                clk_sys_in,
    // Command drive.
    output var logic                                 cmd_valid_out,
    output var sector_prot_pkg::cmd_e                cmd_op_out,
    output var logic [sector_prot_pkg::ADDR_W-1:0]   cmd_addr_out,
    output var logic                                 cmd_dyb_val_out,
    output var logic                                 password_match_out,
    // Answers.
    input  wire logic                                array_write_grant_in,
    input  wire logic                                array_read_grant_in,
    input  wire logic                                array_read_refused_in,
    input  wire logic                                bit_read_valid_in,
    input  wire logic                                bit_read_data_in
);
    import sector_prot_pkg::*;

    initial begin
        cmd_valid_out      = 1'b0;
        cmd_op_out         = CMD_ARRAY_RD;
        cmd_addr_out       = '0;
        cmd_dyb_val_out    = 1'b1;
        password_match_out = 1'b0;
    end

    // One-cycle strobe; the answer pulses are caught in the cycle after the taking edge.
    // The address is held afterwards because a persistent program keeps using it.
    task automatic issue(input cmd_e op, input logic [ADDR_W-1:0] a, input logic v,
                         input logic m, output logic [4:0] ans);
        @(posedge clk_sys_in);
        cmd_valid_out      <= 1'b1;
        cmd_op_out         <= op;
        cmd_addr_out       <= a;
        cmd_dyb_val_out    <= v;
        password_match_out <= m;
        @(posedge clk_sys_in);
        cmd_valid_out      <= 1'b0;
        cmd_dyb_val_out    <= ~v;
        password_match_out <= ~m;
        #1;
        ans = {array_write_grant_in, array_read_grant_in, array_read_refused_in,
               bit_read_valid_in, bit_read_data_in};
    endtask
endmodule
`default_nettype wire

//--- verif/sector_prot_bits_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module sector_prot_bits_tb_top;
    import sector_prot_pkg::*;

    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic soft_reset_in = 1'b0;
    logic password_mode_in = 1'b0;
    logic err_clear_in = 1'b0;
    logic cmd_valid;
    cmd_e cmd_op;
    logic [ADDR_W-1:0] cmd_addr;
    logic cmd_dyb_val;
    logic password_match;
    logic write_in_progress;
    logic lock;
    logic prot_err;
    logic prog_err;
    logic wr_grant;
    logic rd_grant;
    logic rd_refused;
    logic bit_valid;
    logic bit_data;
    logic [4:0] ans;
    int errors = 0;
    int checked = 0;
    int n;

    always #25 clk_sys_in = ~clk_sys_in;

    sector_prot_bits #(.PROG_CYCLES(5), .ERASE_CYCLES(8)) sector_prot_bits_i (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .soft_reset_in(soft_reset_in),
        .password_mode_in(password_mode_in), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
        .cmd_addr_in(cmd_addr), .cmd_dyb_val_in(cmd_dyb_val), .password_match_in(password_match),
        .err_clear_in(err_clear_in), .write_in_progress_out(write_in_progress), .lock_bit_out(lock),
        .protection_error_flag_out(prot_err), .program_error_out(prog_err),
        .array_write_grant_out(wr_grant), .array_read_grant_out(rd_grant),
        .array_read_refused_out(rd_refused), .bit_read_valid_out(bit_valid),
        .bit_read_data_out(bit_data));

    prot_host_model prot_host_model_i (
        .clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op),
        .cmd_addr_out(cmd_addr), .cmd_dyb_val_out(cmd_dyb_val), .password_match_out(password_match),
        .array_write_grant_in(wr_grant), .array_read_grant_in(rd_grant),
        .array_read_refused_in(rd_refused), .bit_read_valid_in(bit_valid),
        .bit_read_data_in(bit_data));

    task automatic finish_test();
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmd(input cmd_e op, input logic [ADDR_W-1:0] a, input logic v, input logic m);
        prot_host_model_i.issue(op, a, v, m, ans);
    endtask

    // Bounded wait on busy; the count is the number of cycles busy was seen high.
    task automatic wait_idle();
        n = 0;
        while (write_in_progress === 1'b1 && n < 3000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        if (n >= 3000) begin
            errors++;
            finish_test();
        end
    endtask

    task automatic hw_reset(input logic mode);
        @(posedge clk_sys_in);
        srst_in          <= 1'b1;
        password_mode_in <= mode;
        repeat (4) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        #1;
    endtask

    task automatic pulse(input int which);
        @(posedge clk_sys_in);
        if (which == 0) err_clear_in <= 1'b1; else soft_reset_in <= 1'b1;
        @(posedge clk_sys_in);
        err_clear_in  <= 1'b0;
        soft_reset_in <= 1'b0;
    endtask

    initial begin
        hw_reset(1'b0);
        chk("lock", 1, lock);
        chk("wip", 0, write_in_progress);
        cmd(CMD_DYB_READ, 25'h0030000, 1'b1, 1'b0);
        chk("dyb_rd", 2'b11, ans[1:0]);
        cmd(CMD_PPB_READ, 25'h1FE1000, 1'b1, 1'b0);
        chk("ppb_rd", 2'b11, ans[1:0]);
        cmd(CMD_DYB_WRITE, 25'h0030000, 1'b0, 1'b0);
        cmd(CMD_ARRAY_WR, 25'h0030000, 1'b1, 1'b0);
        chk("wr_prot", 3'b000, {ans[4], prot_err, prog_err} ^ 3'b011);
        pulse(0);
        cmd(CMD_DYB_WRITE, 25'h0030000, 1'b1, 1'b0);
        cmd(CMD_ARRAY_WR, 25'h0030000, 1'b1, 1'b0);
        chk("wr_ok", 3'b100, {ans[4], prot_err, prog_err});
        cmd(CMD_ARRAY_RD, 25'h0030000, 1'b1, 1'b0);
        chk("rd_ok", 2'b10, ans[3:2]);
        cmd(CMD_PPB_PROG, 25'h1FE1000, 1'b1, 1'b0);
        wait_idle();
        chk("prog_cycles", 5, n[11:0]);
        cmd(CMD_PPB_PROG, 25'h1FE2000, 1'b1, 1'b0);
        cmd(CMD_ARRAY_RD, 25'h1FE2000, 1'b1, 1'b0);
        chk("rd_refused", 2'b01, ans[3:2]);
        wait_idle();
        cmd(CMD_PPB_READ, 25'h1FE1000, 1'b1, 1'b0);
        chk("ppb_511", 2'b10, ans[1:0]);
        cmd(CMD_PPB_READ, 25'h1FE0000, 1'b1, 1'b0);
        chk("ppb_510", 2'b11, ans[1:0]);
        cmd(CMD_ARRAY_WR, 25'h1FE1000, 1'b1, 1'b0);
        chk("wr_ppb", 2'b01, {ans[4], prot_err});
        cmd(CMD_ARRAY_WR, 25'h1FF0000, 1'b1, 1'b0);
        chk("wr_526", 1, ans[4]);
        pulse(0);
        cmd(CMD_PPB_ERASE, 25'h1234567, 1'b1, 1'b0);
        wait_idle();
        chk("erase_cycles", 8, n[11:0]);
        cmd(CMD_PPB_READ, 25'h1FE1000, 1'b1, 1'b0);
        chk("ppb_erased", 2'b11, ans[1:0]);
        // Persistent bits are final here, so the lock may now be dropped.
        cmd(CMD_LOCK_CLEAR, 25'h0000000, 1'b1, 1'b0);
        chk("lock_clr", 0, lock);
        cmd(CMD_PPB_PROG, 25'h0050000, 1'b1, 1'b0);
        chk("prog_locked", 3'b011, {write_in_progress, prot_err, prog_err});
        cmd(CMD_PPB_READ, 25'h0050000, 1'b1, 1'b0);
        chk("ppb_kept", 2'b11, ans[1:0]);
        cmd(CMD_DYB_WRITE, 25'h0050000, 1'b0, 1'b0);
        cmd(CMD_DYB_READ, 25'h0050000, 1'b1, 1'b0);
        chk("dyb_locked", 2'b10, ans[1:0]);
        cmd(CMD_UNLOCK, 25'h0000000, 1'b1, 1'b1);
        chk("lock_persist", 0, lock);
        pulse(1);
        cmd(CMD_DYB_READ, 25'h0050000, 1'b1, 1'b0);
        chk("dyb_soft", 3'b110, {ans[1:0], lock});
        pulse(0);
        hw_reset(1'b1);
        chk("lock_pw", 0, lock);
        cmd(CMD_UNLOCK, 25'h0000000, 1'b1, 1'b0);
        chk("miss", 4'b1110, {write_in_progress, prot_err, prog_err, lock});
        cmd(CMD_UNLOCK, 25'h0000000, 1'b1, 1'b1);
        wait_idle();
        chk("unlock_wait", UNLOCK_CYCLES - 2, n[11:0]);
        chk("lock_busy", 0, lock);
        cmd(CMD_UNLOCK, 25'h0000000, 1'b1, 1'b1);
        chk("unlock_ok", 2'b10, {lock, write_in_progress});
        finish_test();
    end
endmodule
`default_nettype wire
